// ---- design/psc_defs.svh ----
// Purpose: Constants for the pulse scaling and compare configuration block
// Assumes: 10 MHz clock, byte addresses on the register port
// Notes: Types live in psc_pkg
//
// Functional notes
// - Three-second level key hold enters initial level; code is shown.
// - One-second level key hold in initial level returns to operation.
// - Pulse scaling parameters are settable only with input type pulse.
// - Signed five-digit scaling input and display values, upper bound 99999.
// - Input value point: two decimals on 30 Hz range, integer on 5 kHz.
// - Readout is frequency times display value over input value.
// - Display value is accepted only as an integer of five digits at most.
// - Teach indicator is lit while scaling input parameter is selected.
// - Zero on shown input teaches; indicator blinks, live value is shown.
// - Second zero in teaching stores live value as input, back to monitor.
// - Mode key in teaching abandons without storing and advances parameter.
// - Second shift key on a shown value blinks it and allows editing.
// - Edit is committed only on advance; then the next parameter shows.
// - Five readout point positions: four to one decimals or integer.
// - Each of the two comparative outputs keeps its own operating action.
// - Actions are upper-limit, lower-limit or outside-the-range.
// - Outside-the-range uses separate high and low set values per output.
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH

`define PSC_CLK_HZ 10000000
`define PSC_ENTER_MS 3000
`define PSC_LEAVE_MS 1000
`define PSC_BLINK_MS 500
`define PSC_MS_TO_CYC(ms) ((ms) * (`PSC_CLK_HZ / 1000))

`define PSC_VAL_W 18
`define PSC_VAL_MAX 18'sd99999
`define PSC_VAL_MIN (-18'sd19999)
`define PSC_INP_RST 18'sd1000
`define PSC_DSP_RST 18'sd1000
`define PSC_LEVEL_INIT_CODE 4'h5
`define PSC_LEVEL_OP_CODE 4'h0

`define PSC_REG_CTRL 8'h00
`define PSC_REG_STATUS 8'h04
`define PSC_REG_INP 8'h08
`define PSC_REG_DSP 8'h0c
`define PSC_REG_MODE 8'h10
`define PSC_REG_SV1 8'h14
`define PSC_REG_SV1H 8'h18
`define PSC_REG_SV1L 8'h1c
`define PSC_REG_SV2 8'h20
`define PSC_REG_SV2H 8'h24
`define PSC_REG_SV2L 8'h28
`define PSC_REG_READOUT 8'h2c

`define PSC_CTRL_PULSE_BIT 0
`define PSC_CTRL_RANGE_BIT 1
`define PSC_MODE_POINT_LSB 0
`define PSC_MODE_ACT1_LSB 4
`define PSC_MODE_ACT2_LSB 8

`define PSC_POINT_INT 3'd0
`define PSC_POINT_MAX 3'd4
`define PSC_INP_POINT_30HZ 3'd2
`define PSC_INP_POINT_5KHZ 3'd0

`endif

// ---- design/psc_pkg.sv ----
// Purpose: Types for the pulse scaling and compare configuration block
// Assumes: Constants come from psc_defs.svh
// Notes: None
package psc_pkg;
	typedef enum logic [1:0] {ACT_UPPER, ACT_LOWER, ACT_OUTSIDE} psc_action_t;
	typedef enum logic [2:0] {P_INP, P_DSP, P_POINT, P_ACT1, P_ACT2} psc_param_t;
	typedef enum logic [1:0] {M_NAME, M_SHOW, M_EDIT, M_TEACH} psc_menu_t;
	typedef struct packed {
		logic level;
		logic mode;
		logic shift;
		logic zero;
	} psc_keys_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} psc_bus_t;
endpackage

// ---- design/psc_hold_timer.sv ----
// Purpose: Fires one pulse when a level has stood for LIMIT cycles
// Assumes: Input is already synchronised
// Notes: Saturates, so it fires once per hold
`timescale 1ns/1ps
module psc_hold_timer #(
	parameter int LIMIT = 10000000
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Level and event
	input wire logic held_i,
	output logic fire_o
);
	initial begin
		if (LIMIT < 2) begin
			$error("psc_hold_timer: LIMIT too small");
		end
	end

	logic [31:0] cnt_q, cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (!held_i) begin
			cnt_d = '0;
		end else if (cnt_q != 32'(LIMIT)) begin
			cnt_d = cnt_q + 32'd1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign fire_o = held_i && (cnt_q == 32'(LIMIT - 1));
endmodule // psc_hold_timer

// ---- design/psc_divider.sv ----
// Purpose: Sequential restoring divider, unsigned
// Assumes: Divisor is nonzero when started
// Notes: NW cycles per quotient; a trade of speed for area
`timescale 1ns/1ps
module psc_divider #(
	parameter int NW = 35,
	parameter int DW = 17
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Request
	input wire logic start_i,
	input wire logic [NW-1:0] num_i,
	input wire logic [DW-1:0] den_i,
	// Answer
	output logic done_o,
	output logic [NW-1:0] quot_o
);
	initial begin
		if (NW < DW || DW < 2 || NW > 255) begin
			$error("psc_divider: bad widths");
		end
	end

	logic [NW-1:0] q_q, q_d;
	logic [DW:0] rem_q, rem_d;
	logic [DW-1:0] den_q, den_d;
	logic [7:0] cnt_q, cnt_d;
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic [NW-1:0] res_q, res_d;

	always_comb begin
		logic [DW:0] sh;
		sh = {rem_q[DW-1:0], q_q[NW-1]};
		q_d = q_q;
		rem_d = rem_q;
		den_d = den_q;
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		res_d = res_q;
		if (!busy_q) begin
			if (start_i) begin
				q_d = num_i;
				rem_d = '0;
				den_d = den_i;
				cnt_d = 8'(NW);
				busy_d = 1'b1;
			end
		end else begin
			q_d = {q_q[NW-2:0], 1'b0};
			rem_d = sh;
			if (sh >= {1'b0, den_q}) begin
				rem_d = sh - {1'b0, den_q};
				q_d[0] = 1'b1;
			end
			cnt_d = cnt_q - 8'd1;
			if (cnt_q == 8'd1) begin
				busy_d = 1'b0;
				done_d = 1'b1;
				res_d = q_d;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q_q <= '0;
			rem_q <= '0;
			den_q <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			res_q <= '0;
		end else begin
			q_q <= q_d;
			rem_q <= rem_d;
			den_q <= den_d;
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
			res_q <= res_d;
		end
	end

	assign done_o = done_q;
	assign quot_o = res_q;
endmodule // psc_divider

// ---- design/psc_config.sv ----
// Purpose: Key driven scaling set-up, readout scaling, comparative outputs
// Assumes: freq_i is the live pulse value in units of the input value point
// Notes: Keys are pins and are synchronised here
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "psc_defs.svh"
module psc_config
	import psc_pkg::*;
#(
	parameter int ENTER_CYC = `PSC_MS_TO_CYC(`PSC_ENTER_MS),
	parameter int LEAVE_CYC = `PSC_MS_TO_CYC(`PSC_LEAVE_MS),
	parameter int BLINK_CYC = `PSC_MS_TO_CYC(`PSC_BLINK_MS)
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Front panel keys, asynchronous pins
	input wire psc_keys_t keys_i,
	// Live process value
	input wire logic [16:0] freq_i,
	// Register port
	input wire psc_bus_t bus_i,
	output logic [31:0] rdata_o,
	// Display
	output logic [3:0] level_code_o,
	output logic signed [17:0] disp_value_o,
	output logic [2:0] disp_point_o,
	output logic disp_blank_o,
	output logic [2:0] disp_param_o,
	output logic disp_shows_name_o,
	output logic teach_led_o,
	// Comparative outputs
	output logic out1_o,
	output logic out2_o
);
	initial begin
		if (ENTER_CYC <= LEAVE_CYC || BLINK_CYC < 2) begin
			$error("psc_config: bad timing parameters");
		end
	end

	typedef logic signed [17:0] val_t;

	// Key synchroniser: a change counts when stages two and three agree
	psc_keys_t s1_q, s2_q, s3_q, key_q, key_d, prev_q;
	psc_keys_t press;
	always_comb begin
		key_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & key_q);
		press = key_q & ~prev_q;
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			key_q <= '0;
			prev_q <= '0;
		end else begin
			s1_q <= keys_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			key_q <= key_d;
			prev_q <= key_q;
		end
	end

	logic enter_hit, leave_hit;
	psc_hold_timer #(.LIMIT(ENTER_CYC)) u_enter (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.held_i(key_q.level),
		.fire_o(enter_hit)
	);
	psc_hold_timer #(.LIMIT(LEAVE_CYC)) u_leave (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.held_i(key_q.level),
		.fire_o(leave_hit)
	);

	// Settings and menu state
	logic init_q, init_d;
	psc_menu_t menu_q, menu_d;
	psc_param_t par_q, par_d;
	val_t inp_q, inp_d, dsp_q, dsp_d, edit_q, edit_d;
	logic [2:0] digit_q, digit_d;
	logic [2:0] readout_point_position_q, readout_point_position_d;
	psc_action_t act1_q, act1_d, act2_q, act2_d;
	logic pulse_q, range5k_q;
	val_t sv_q [6];
	logic [31:0] blink_q, blink_d;
	logic blink_ph_q, blink_ph_d;
	val_t live;

	// Live value is clamped to the setting range
	assign live = (freq_i > 17'd99999) ? `PSC_VAL_MAX : val_t'({1'b0, freq_i});

	function automatic psc_param_t next_par(psc_param_t p, logic pulse);
		psc_param_t n;
		case (p)
			P_INP: n = P_DSP;
			P_DSP: n = P_POINT;
			P_POINT: n = P_ACT1;
			P_ACT1: n = P_ACT2;
			default: n = pulse ? P_INP : P_POINT;
		endcase
		return n;
	endfunction

	function automatic val_t digit_step(logic [2:0] d);
		val_t s;
		case (d)
			3'd0: s = 18'sd1;
			3'd1: s = 18'sd10;
			3'd2: s = 18'sd100;
			3'd3: s = 18'sd1000;
			default: s = 18'sd10000;
		endcase
		return s;
	endfunction

	always_comb begin
		val_t cur, sum;
		logic numeric;
		cur = inp_q;
		case (par_q)
			P_INP: cur = inp_q;
			P_DSP: cur = dsp_q;
			P_POINT: cur = val_t'(readout_point_position_q);
			P_ACT1: cur = val_t'(act1_q);
			default: cur = val_t'(act2_q);
		endcase
		numeric = (par_q == P_INP) || (par_q == P_DSP);
		sum = edit_q + digit_step(digit_q);
		init_d = init_q;
		menu_d = menu_q;
		par_d = par_q;
		inp_d = inp_q;
		dsp_d = dsp_q;
		edit_d = edit_q;
		digit_d = digit_q;
		readout_point_position_d = readout_point_position_q;
		act1_d = act1_q;
		act2_d = act2_q;
		if (!init_q) begin
			if (enter_hit) begin
				init_d = 1'b1;
				menu_d = M_NAME;
				par_d = pulse_q ? P_INP : P_POINT;
			end
		end else if (leave_hit) begin
			init_d = 1'b0;
			menu_d = M_NAME;
		end else begin
			case (menu_q)
				M_NAME: begin
					if (press.shift) begin
						menu_d = M_SHOW;
					end else if (press.mode) begin
						par_d = next_par(par_q, pulse_q);
					end
				end
				M_SHOW: begin
					if (press.shift) begin
						menu_d = M_EDIT;
						edit_d = cur;
						digit_d = 3'd0;
					end else if (press.zero && par_q == P_INP) begin
						menu_d = M_TEACH;
					end else if (press.mode) begin
						menu_d = M_NAME;
						par_d = next_par(par_q, pulse_q);
					end
				end
				M_EDIT: begin
					if (press.shift && numeric) begin
						digit_d = (digit_q == 3'd4) ? 3'd0 : digit_q + 3'd1;
					end else if (press.zero) begin
						if (numeric) begin
							// Integer steps only, wrap keeps five digits
							edit_d = (sum > `PSC_VAL_MAX) ? `PSC_VAL_MIN : sum;
						end else if (par_q == P_POINT) begin
							edit_d = (edit_q >= val_t'(`PSC_POINT_MAX)) ?
								val_t'(`PSC_POINT_INT) : edit_q + 18'sd1;
						end else begin
							edit_d = (edit_q >= val_t'(ACT_OUTSIDE)) ?
								val_t'(ACT_UPPER) : edit_q + 18'sd1;
						end
					end else if (press.mode) begin
						// Commit happens only here, on advance
						case (par_q)
							P_INP: if (pulse_q) inp_d = edit_q;
							P_DSP: if (pulse_q) dsp_d = edit_q;
							P_POINT: readout_point_position_d = edit_q[2:0];
							P_ACT1: act1_d = psc_action_t'(edit_q[1:0]);
							default: act2_d = psc_action_t'(edit_q[1:0]);
						endcase
						menu_d = M_NAME;
						par_d = next_par(par_q, pulse_q);
					end
				end
				M_TEACH: begin
					if (press.zero) begin
						if (pulse_q) begin
							inp_d = live;
						end
						menu_d = M_SHOW;
					end else if (press.mode) begin
						menu_d = M_NAME;
						par_d = next_par(par_q, pulse_q);
					end
				end
				default: menu_d = M_NAME;
			endcase
		end
		blink_d = (blink_q == 32'(BLINK_CYC - 1)) ? '0 : blink_q + 32'd1;
		blink_ph_d = (blink_q == 32'(BLINK_CYC - 1)) ? ~blink_ph_q : blink_ph_q;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			init_q <= 1'b0;
			menu_q <= M_NAME;
			par_q <= P_INP;
			inp_q <= `PSC_INP_RST;
			dsp_q <= `PSC_DSP_RST;
			edit_q <= '0;
			digit_q <= '0;
			readout_point_position_q <= `PSC_POINT_INT;
			act1_q <= ACT_UPPER;
			act2_q <= ACT_UPPER;
			blink_q <= '0;
			blink_ph_q <= 1'b0;
		end else begin
			init_q <= init_d;
			menu_q <= menu_d;
			par_q <= par_d;
			inp_q <= inp_d;
			dsp_q <= dsp_d;
			edit_q <= edit_d;
			digit_q <= digit_d;
			readout_point_position_q <= readout_point_position_d;
			act1_q <= act1_d;
			act2_q <= act2_d;
			blink_q <= blink_d;
			blink_ph_q <= blink_ph_d;
		end
	end

	// Scaling: |f*dsp| + |inp|/2 over |inp| rounds to nearest
	logic [16:0] dsp_mag, inp_mag;
	logic [34:0] num;
	logic div_done;
	logic [34:0] quot;
	logic neg_q, neg_d;
	val_t readout_q, readout_d;
	assign dsp_mag = dsp_q[17] ? 17'(-dsp_q) : dsp_q[16:0];
	assign inp_mag = inp_q[17] ? 17'(-inp_q) : inp_q[16:0];
	// Widen before the product so no bits of f*dsp are lost
	assign num = 35'(freq_i) * 35'(dsp_mag) + 35'(inp_mag >> 1);

	psc_divider #(.NW(35), .DW(17)) u_div (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.start_i(inp_mag != 17'd0),
		.num_i(num),
		.den_i(inp_mag),
		.done_o(div_done),
		.quot_o(quot)
	);

	always_comb begin
		neg_d = dsp_q[17] ^ inp_q[17];
		readout_d = readout_q;
		if (inp_mag == 17'd0) begin
			readout_d = '0;
		end else if (div_done) begin
			if (!neg_q) begin
				readout_d = (quot > 35'd99999) ? `PSC_VAL_MAX : val_t'(quot);
			end else begin
				readout_d = (quot > 35'd19999) ? `PSC_VAL_MIN : -val_t'(quot);
			end
		end
	end

	// Comparative outputs on the rounded count
	logic out1_d, out2_d;
	function automatic logic judge(psc_action_t a, val_t r, val_t sv,
		val_t hi, val_t lo);
		logic o;
		case (a)
			ACT_UPPER: o = r > sv;
			ACT_LOWER: o = r < sv;
			default: o = (r > hi) || (r < lo);
		endcase
		return o;
	endfunction
	assign out1_d = judge(act1_q, readout_q, sv_q[0], sv_q[1], sv_q[2]);
	assign out2_d = judge(act2_q, readout_q, sv_q[3], sv_q[4], sv_q[5]);

	// Display and indicator outputs
	logic [3:0] lvl_d;
	val_t disp_d;
	logic [2:0] pt_d;
	logic blank_d, name_d, tled_d;
	always_comb begin
		lvl_d = init_q ? `PSC_LEVEL_INIT_CODE : `PSC_LEVEL_OP_CODE;
		disp_d = readout_q;
		pt_d = readout_point_position_q;
		blank_d = 1'b0;
		name_d = init_q && (menu_q == M_NAME);
		if (init_q) begin
			case (menu_q)
				M_SHOW: disp_d = (par_q == P_INP) ? inp_q : (par_q == P_DSP) ?
					dsp_q : (par_q == P_POINT) ? val_t'(readout_point_position_q) :
					(par_q == P_ACT1) ? val_t'(act1_q) : val_t'(act2_q);
				M_EDIT: begin
					disp_d = edit_q;
					blank_d = blink_ph_q;
				end
				M_TEACH: disp_d = live;
				default: disp_d = '0;
			endcase
			// Input value point follows the frequency range
			pt_d = (par_q == P_INP) ? (range5k_q ? `PSC_INP_POINT_5KHZ :
				`PSC_INP_POINT_30HZ) : (par_q == P_DSP) ? `PSC_POINT_INT :
				readout_point_position_q;
		end
		tled_d = init_q && par_q == P_INP;
		if (menu_q == M_TEACH) begin
			tled_d = init_q && blink_ph_q;
		end
	end

	// Register port, read data one cycle after the strobe
	logic [31:0] rd_d;
	always_comb begin
		rd_d = '0;
		if (bus_i.rd) begin
			case (bus_i.addr)
				`PSC_REG_CTRL: rd_d = {30'd0, range5k_q, pulse_q};
				`PSC_REG_STATUS: rd_d = {24'd0, par_q, menu_q,
					menu_q == M_TEACH, menu_q == M_EDIT, init_q};
				`PSC_REG_INP: rd_d = 32'(inp_q);
				`PSC_REG_DSP: rd_d = 32'(dsp_q);
				`PSC_REG_MODE: rd_d = {22'd0, act2_q, 2'd0, act1_q, 1'b0,
					readout_point_position_q};
				`PSC_REG_SV1: rd_d = 32'(sv_q[0]);
				`PSC_REG_SV1H: rd_d = 32'(sv_q[1]);
				`PSC_REG_SV1L: rd_d = 32'(sv_q[2]);
				`PSC_REG_SV2: rd_d = 32'(sv_q[3]);
				`PSC_REG_SV2H: rd_d = 32'(sv_q[4]);
				`PSC_REG_SV2L: rd_d = 32'(sv_q[5]);
				`PSC_REG_READOUT: rd_d = 32'(readout_q);
				default: rd_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pulse_q <= 1'b1;
			range5k_q <= 1'b1;
			for (int i = 0; i < 6; i++) begin
				sv_q[i] <= '0;
			end
			neg_q <= 1'b0;
			readout_q <= '0;
			rdata_o <= '0;
			level_code_o <= `PSC_LEVEL_OP_CODE;
			disp_value_o <= '0;
			disp_point_o <= '0;
			disp_blank_o <= 1'b0;
			disp_param_o <= '0;
			disp_shows_name_o <= 1'b0;
			teach_led_o <= 1'b0;
			out1_o <= 1'b0;
			out2_o <= 1'b0;
		end else begin
			if (bus_i.wr && bus_i.addr == `PSC_REG_CTRL) begin
				pulse_q <= bus_i.wdata[`PSC_CTRL_PULSE_BIT];
				range5k_q <= bus_i.wdata[`PSC_CTRL_RANGE_BIT];
			end
			for (int i = 0; i < 6; i++) begin
				if (bus_i.wr && bus_i.addr == 8'(`PSC_REG_SV1 + 4 * i)) begin
					sv_q[i] <= val_t'(bus_i.wdata[17:0]);
				end
			end
			neg_q <= neg_d;
			readout_q <= readout_d;
			rdata_o <= rd_d;
			level_code_o <= lvl_d;
			disp_value_o <= disp_d;
			disp_point_o <= pt_d;
			disp_blank_o <= blank_d;
			disp_param_o <= par_q;
			disp_shows_name_o <= name_d;
			teach_led_o <= tled_d;
			out1_o <= out1_d;
			out2_o <= out2_d;
		end
	end
endmodule // psc_config

// ---- verif/psc_config_props.sv ----
// Purpose: Port-level checks of the scaling and compare set-up block
// Assumes: Hold counts shortened by parameters in the bench
// Notes: Sees only the top ports; bound after the module
`timescale 1ns/1ps
module psc_config_props
	import psc_pkg::*;
#(
	parameter int ENTER_CYC = 40,
	parameter int LEAVE_CYC = 12,
	parameter int BLINK_CYC = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Inputs
	input wire psc_keys_t keys_i,
	input wire logic [16:0] freq_i,
	input wire psc_bus_t bus_i,
	// Outputs
	input wire logic [31:0] rdata_o,
	input wire logic [3:0] level_code_o,
	input wire logic signed [17:0] disp_value_o,
	input wire logic [2:0] disp_point_o,
	input wire logic disp_blank_o,
	input wire logic [2:0] disp_param_o,
	input wire logic disp_shows_name_o,
	input wire logic teach_led_o,
	input wire logic out1_o,
	input wire logic out2_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic in_init;
	logic shows_val;
	assign in_init = (level_code_o == 4'h5);
	assign shows_val = in_init && !disp_shows_name_o;

	level_code_a: assert property (in_init || level_code_o == 4'h0)
		else $error("level code outside 0 and 5");
	enter_hold_a: assert property ($rose(in_init) |->
		$past(keys_i.level, ENTER_CYC))
		else $error("initial level entered without a long hold");
	leave_hold_a: assert property ($fell(in_init) |->
		$past(keys_i.level, LEAVE_CYC))
		else $error("initial level left without a hold");
	teach_led_off_a: assert property (in_init && disp_param_o != 3'h0
		|-> !teach_led_o)
		else $error("teach indicator lit off the input value");
	value_bound_a: assert property (disp_value_o <= 18'sh1869f)
		else $error("display value above upper bound");
	dsp_point_a: assert property (shows_val && disp_param_o == 3'h1
		|-> disp_point_o == 3'h0)
		else $error("display value not integer");
	blank_edit_a: assert property (disp_blank_o |-> shows_val)
		else $error("blinking outside value display");
	point_value_a: assert property (shows_val && disp_param_o == 3'h2
		|-> disp_value_o inside {[0:4]})
		else $error("point position out of range");
	act_value_a: assert property (shows_val && disp_param_o == 3'h3
		|-> disp_value_o inside {[0:2]})
		else $error("output action out of range");

	enter_c: cover property ($rose(in_init));
	blink_c: cover property ($rose(disp_blank_o));
	out_both_c: cover property (out1_o && out2_o);
endmodule // psc_config_props

bind psc_config psc_config_props #(
	.ENTER_CYC(ENTER_CYC),
	.LEAVE_CYC(LEAVE_CYC),
	.BLINK_CYC(BLINK_CYC)
) u_psc_config_props (.*);

// ---- verif/psc_operator.sv ----
// Purpose: Operator at the front panel keys
// Assumes: Key index 3 level, 2 mode, 1 shift, 0 zero
// Notes: Released keys read low, as with a pull-down
`timescale 1ns/1ps
module psc_operator
	import psc_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Keys
	output psc_keys_t keys_o
);
	initial keys_o = '0;
	// Long gap after release lets the synchroniser settle between presses
	task automatic hold(input int k, input int n);
		@(posedge clk_i);
		keys_o[k] <= 1'b1;
		repeat (n) @(posedge clk_i);
		keys_o[k] <= 1'b0;
		repeat (12) @(posedge clk_i);
	endtask
	task automatic tap(input int k);
		hold(k, 8);
	endtask
endmodule // psc_operator

// ---- verif/psc_config_tb_top.sv ----
// Purpose: Self-checking bench for the scaling and compare set-up block
// Assumes: Short hold counts 40, 12 and blink 4
// Notes: Expected values worked out by hand below
`timescale 1ns/1ps
module psc_config_tb_top;
	import psc_pkg::*;
	localparam int ENTER = 40;
	localparam int LEAVE = 12;
	localparam int KL = 3, KM = 2, KS = 1, KZ = 0;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	psc_keys_t keys;
	logic [16:0] freq_i = 17'h0;
	psc_bus_t bus_i = '0;
	logic [31:0] rdata_o;
	logic [3:0] level_code_o;
	logic signed [17:0] disp_value_o;
	logic [2:0] disp_point_o, disp_param_o;
	logic disp_blank_o, disp_shows_name_o, teach_led_o, out1_o, out2_o;
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;

	psc_config #(.ENTER_CYC(ENTER), .LEAVE_CYC(LEAVE), .BLINK_CYC(4))
		u_psc_config (
		.clk_i(clk_i), .reset_i(reset_i), .keys_i(keys), .freq_i(freq_i),
		.bus_i(bus_i), .rdata_o(rdata_o), .level_code_o(level_code_o),
		.disp_value_o(disp_value_o), .disp_point_o(disp_point_o),
		.disp_blank_o(disp_blank_o), .disp_param_o(disp_param_o),
		.disp_shows_name_o(disp_shows_name_o), .teach_led_o(teach_led_o),
		.out1_o(out1_o), .out2_o(out2_o));
	psc_operator u_psc_operator (.clk_i(clk_i), .keys_o(keys));

	initial begin
		forever #50 clk_i = ~clk_i;
	end

	task automatic end_sim();
		$display("compares %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		bus_i.addr <= a;
		bus_i.wdata <= d;
		bus_i.wr <= 1'b1;
		@(posedge clk_i);
		bus_i.wr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		bus_i.addr <= a;
		bus_i.rd <= 1'b1;
		@(posedge clk_i);
		bus_i.rd <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask

	task automatic val(input logic [31:0] exp);
		chk(32'(disp_value_o), exp);
	endtask

	// Both phases of a blinking signal must show within a few periods
	task automatic blinks(input int w);
		logic [1:0] seen;
		seen = 2'b00;
		repeat (20) begin
			@(posedge clk_i);
			#1 seen[(w == 0) ? disp_blank_o : teach_led_o] = 1'b1;
		end
		chk(32'(seen), 32'h3);
	endtask

	// Step a coded setting through all m codes, then settle on last
	task automatic walk(input int m, input int last);
		u_psc_operator.tap(KS);
		u_psc_operator.tap(KS);
		for (int i = 1; i <= m; i++) begin
			u_psc_operator.tap(KZ);
			val(32'(i % m));
		end
		repeat (last) u_psc_operator.tap(KZ);
		u_psc_operator.tap(KM);
	endtask

	task automatic readout(input logic [16:0] f, input logic [31:0] exp);
		@(posedge clk_i);
		freq_i <= f;
		repeat (120) @(posedge clk_i);
		rdc(8'h2c, exp);
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		rdc(8'h08, 32'h3e8);
		rdc(8'h0c, 32'h3e8);
		rdc(8'h10, 32'h0);
		rdc(8'h00, 32'h3);
		rdc(8'h30, 32'h0);
		u_psc_operator.hold(KL, ENTER - 20);
		chk(32'(level_code_o), 32'h0);
		u_psc_operator.hold(KL, ENTER + 10);
		chk(32'(level_code_o), 32'h5);
		chk(32'(disp_param_o), 32'h0);
		chk(32'(teach_led_o), 32'h1);
		u_psc_operator.tap(KS);
		val(32'h3e8);
		chk(32'(disp_point_o), 32'h0);
		wr(8'h00, 32'h1);
		repeat (4) @(posedge clk_i);
		chk(32'(disp_point_o), 32'h2);
		wr(8'h00, 32'h3);
		u_psc_operator.tap(KS);
		rdc(8'h04, 32'h13);
		blinks(0);
		u_psc_operator.tap(KZ);
		val(32'h3e9);
		rdc(8'h08, 32'h3e8);
		u_psc_operator.tap(KM);
		rdc(8'h08, 32'h3e9);
		chk(32'(disp_param_o), 32'h1);
		chk(32'(disp_shows_name_o), 32'h1);
		u_psc_operator.tap(KM);
		walk(5, 2);
		walk(3, 2);
		walk(3, 1);
		rdc(8'h10, 32'h122);
		chk(32'(disp_param_o), 32'h0);
		u_psc_operator.tap(KS);
		freq_i <= 17'h9c4;
		u_psc_operator.tap(KZ);
		rdc(8'h04, 32'h1d);
		val(32'h9c4);
		blinks(1);
		u_psc_operator.tap(KZ);
		rdc(8'h08, 32'h9c4);
		rdc(8'h04, 32'h09);
		freq_i <= 17'h1ffff;
		u_psc_operator.tap(KZ);
		u_psc_operator.tap(KZ);
		rdc(8'h08, 32'h1869f);
		freq_i <= 17'h9c4;
		u_psc_operator.tap(KZ);
		u_psc_operator.tap(KZ);
		u_psc_operator.tap(KZ);
		freq_i <= 17'hbb8;
		u_psc_operator.tap(KM);
		chk(32'(disp_param_o), 32'h1);
		rdc(8'h08, 32'h9c4);
		readout(17'h138a, 32'h7d1);
		readout(17'h1389, 32'h7d0);
		wr(8'h14, 32'h0);
		wr(8'h18, 32'h9c4);
		wr(8'h1c, 32'h5dc);
		wr(8'h20, 32'h3e8);
		rdc(8'h18, 32'h9c4);
		readout(17'h1388, 32'h7d0);
		chk(32'({out1_o, out2_o}), 32'h0);
		readout(17'h1b58, 32'haf0);
		chk(32'({out1_o, out2_o}), 32'h2);
		readout(17'h7d0, 32'h320);
		chk(32'({out1_o, out2_o}), 32'h3);
		// Edit the display value on the tens digit, then make output 1 upper
		u_psc_operator.tap(KS);
		u_psc_operator.tap(KS);
		u_psc_operator.tap(KS);
		u_psc_operator.tap(KZ);
		val(32'h3f2);
		u_psc_operator.tap(KM);
		rdc(8'h0c, 32'h3f2);
		u_psc_operator.tap(KM);
		u_psc_operator.tap(KS);
		u_psc_operator.tap(KS);
		u_psc_operator.tap(KZ);
		val(32'h0);
		u_psc_operator.tap(KM);
		rdc(8'h10, 32'h102);
		wr(8'h14, 32'h7d0);
		readout(17'h9c4, 32'h3f2);
		chk(32'({out1_o, out2_o}), 32'h0);
		readout(17'h1388, 32'h7e4);
		chk(32'({out1_o, out2_o}), 32'h2);
		u_psc_operator.hold(KL, LEAVE + 6);
		chk(32'(level_code_o), 32'h0);
		wr(8'h00, 32'h2);
		u_psc_operator.hold(KL, ENTER + 10);
		chk(32'(disp_param_o), 32'h2);
		u_psc_operator.hold(KL, LEAVE + 6);
		chk(32'(level_code_o), 32'h0);
		end_sim();
	end
endmodule // psc_config_tb_top
